/* switch_fault_defs.svh */
// Constants for the switch fault recovery block
`ifndef SWITCH_FAULT_DEFS_SVH
`define SWITCH_FAULT_DEFS_SVH
`define ADDR_CTRL        4'h0
`define ADDR_RETRY       4'h1
`define ADDR_CONFIG      4'h2
`define ADDR_STATUS      4'h3
`define ADDR_FAULT       4'h4
`define ADDR_RETRYCNT    4'h5
`define CTRL_SUPFAIL_EN  0
`define CTRL_NORMAL_MODE 1
`define CTRL_DELATCH0    2
`define CTRL_DELATCH1    3
`define RETRY_EN_BIT     0
`define RETRY_UNLIM_BIT  1
`define RETRY_PER_LO     2
`define RETRY_PER_HI     3
`define CFG_OS_DIS       6
`define CFG_OFF_OL_DIS   7
`define CFG_ON_OL_DIS    8
`define STAT_FULL0       4
`define STAT_FULL1       5
`define STAT_POR         6
`define RETRY_MAX        4'hF
`define RETRY_PERIOD_0_MS 8
`define RETRY_PERIOD_1_MS 16
`define RETRY_PERIOD_2_MS 32
`define RETRY_PERIOD_3_MS 64
`define CLK_HZ           10000000
`define MS_CYCLES(ms)    ((ms) * (`CLK_HZ / 1000))
`endif

/* switch_fault_pkg.sv */
// Types for the switch fault recovery block
package switch_fault_pkg;
  typedef enum logic [1:0] {
    CH_NORMAL,
    CH_WAIT_CLEAR,
    CH_RETRY_WAIT,
    CH_LATCHED
  } chan_state_e;
  typedef logic [15:0] word_t;
endpackage

/* retry_channel.sv */
// One channel of the auto-retry sequencer with its retry counter
`timescale 1ns/100ps
`default_nettype none
`include "switch_fault_defs.svh"
module retry_channel
  import switch_fault_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_cnt_clear,
  input  wire logic        i_retry_en,
  input  wire logic        i_unlimited,
  input  wire logic [1:0]  i_period_sel,
  input  wire logic        i_fault_control_signal,
  input  wire logic        i_overcurrent_fault,
  input  wire logic        i_severe_short_fault,
  input  wire logic        i_overtemperature_fault,
  input  wire logic        i_undervoltage_fault,
  input  wire logic        i_delatch,
  input  wire logic        i_motor,
  input  wire logic        i_pwm_off_clean,
  output logic             o_on_allow,
  output logic             o_latched,
  output logic             o_full,
  output logic             o_oc_dur_reset,
  output logic [3:0]       o_count
);
  import switch_fault_pkg::*;
  localparam int unsigned P0 = `MS_CYCLES(`RETRY_PERIOD_0_MS);
  localparam int unsigned P1 = `MS_CYCLES(`RETRY_PERIOD_1_MS);
  localparam int unsigned P2 = `MS_CYCLES(`RETRY_PERIOD_2_MS);
  localparam int unsigned P3 = `MS_CYCLES(`RETRY_PERIOD_3_MS);
  chan_state_e  state_q;
  logic [19:0]  timer_q;
  logic [19:0]  period;
  logic         retry_cond;
  logic         slow_fault;
  logic         expired;
  assign retry_cond = i_overcurrent_fault | i_severe_short_fault | i_overtemperature_fault | i_undervoltage_fault;
  assign slow_fault = i_overtemperature_fault | i_undervoltage_fault;
  always_comb begin
    case (i_period_sel)
      2'h0:    period = 20'(P0);
      2'h1:    period = 20'(P1);
      2'h2:    period = 20'(P2);
      default: period = 20'(P3);
    endcase
  end
  assign expired = (timer_q >= period - 20'h00001);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= CH_NORMAL;
    end else begin
      case (state_q)
        CH_NORMAL: begin
          if (i_fault_control_signal && retry_cond) begin
            if (!i_retry_en)
              state_q <= CH_LATCHED;
            else if (slow_fault)
              state_q <= CH_WAIT_CLEAR;
            else
              state_q <= CH_RETRY_WAIT;
          end
        end
        CH_WAIT_CLEAR: begin
          if (i_delatch)
            state_q <= CH_NORMAL;
          else if (!i_retry_en)
            state_q <= CH_LATCHED;
          else if (!slow_fault)
            state_q <= CH_RETRY_WAIT;
        end
        CH_RETRY_WAIT: begin
          if (i_delatch)
            state_q <= CH_NORMAL;
          else if (!i_retry_en)
            state_q <= CH_LATCHED;
          else if (expired) begin
            if (!i_unlimited && o_full && retry_cond)
              state_q <= CH_LATCHED;
            else
              state_q <= CH_NORMAL;
          end
        end
        CH_LATCHED: begin
          if (i_delatch)
            state_q <= CH_NORMAL;
          else if (i_cnt_clear && i_unlimited && i_retry_en)
            state_q <= CH_RETRY_WAIT;
        end
        default: state_q <= CH_NORMAL;
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst || state_q != CH_RETRY_WAIT)
      timer_q <= 20'h00000;
    else if (!expired)
      timer_q <= timer_q + 20'h00001;
  end
  // Counter kept across delatch and recovery; cleared only by listed events
  always_ff @(posedge i_clk) begin
    if (i_rst || i_cnt_clear) begin
      o_count <= 4'h0;
      o_full  <= 1'b0;
    end else if (state_q == CH_RETRY_WAIT && expired && !i_delatch && !i_unlimited) begin
      if (o_count == `RETRY_MAX - 4'h1 || o_count == `RETRY_MAX)
        o_full <= 1'b1;
      if (o_count != `RETRY_MAX)
        o_count <= o_count + 4'h1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst)
      o_oc_dur_reset <= 1'b0;
    else if (i_motor)
      o_oc_dur_reset <= i_pwm_off_clean;
    else
      o_oc_dur_reset <= (state_q == CH_RETRY_WAIT) && expired;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_on_allow <= 1'b1;
      o_latched  <= 1'b0;
    end else begin
      o_on_allow <= (state_q == CH_NORMAL);
      o_latched  <= (state_q == CH_LATCHED);
    end
  end
endmodule
`default_nettype wire

/* switch_fault_autoretry.sv */
// Fault recovery top: registers, supply handling and two retry channels
`timescale 1ns/100ps
`default_nettype none
`include "switch_fault_defs.svh"
// Notes on behaviour
// - Logic supply fail with enable set enters fail-safe, clears registers, inputs drive.
// - Logic supply fail with enable clear keeps serial-port control.
// - Power undervoltage with valid logic supply still serves register accesses.
// - Power-up of either supply runs reset and sets status bit 6; code detects it only when both POR inputs were high the cycle before.
// - Wake transition via reset input or direct input also sets status bit 6.
// - Retry condition is overcurrent, short or overtemperature, or common undervoltage.
// - Undervoltage and overtemperature retries start only after the cause clears.
// - Retry enabled only when enable bit equals channel load type.
// - Retry disabled latches latchable faults at once.
// - Sequence starts only with fault control high and retry condition true.
// - Channel retries on after selected retry period expires.
// - Cause cleared early resumes normal, counter and fault bit kept.
// - Unlimited mode retries forever, never latches off.
// - Limited mode counts retries; at fifteen sets full bit, one more allowed.
// - Fault at final retry latches channel off, fault pin low.
// - Delatch during retry turns channel on without clearing counter.
// - Counter readable only in normal mode.
// - Counter cleared by fail-safe, wake, reset, unlimited, or retry disable.
// - Latched channel reset by unlimited select retries after one period.
// - Lamp resets overcurrent duration each retry; motor in every cycle its clean PWM-off input is high.
// - Passive open-load and short-to-supply faults set bits and pull fault pin low, maskable; no retry.
module switch_fault_autoretry
  import switch_fault_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [3:0]  i_avm_address,
  input  wire logic        i_avm_read,
  input  wire logic        i_avm_write,
  input  wire logic [31:0] i_avm_writedata,
  output logic [31:0]      o_avm_readdata,
  output logic             o_avm_waitrequest,
  input  wire logic        i_logic_supply_ok,
  input  wire logic        i_power_supply_por,
  input  wire logic        i_logic_supply_por,
  input  wire logic        i_reset_wake_input_n,
  input  wire logic [1:0]  i_direct_in,
  input  wire logic [1:0]  i_load_type_select,
  input  wire logic [1:0]  i_fault_control_signal,
  input  wire logic [1:0]  i_overcurrent_fault,
  input  wire logic [1:0]  i_severe_short_fault,
  input  wire logic [1:0]  i_overtemperature_fault,
  input  wire logic        i_undervoltage_fault,
  input  wire logic [1:0]  i_on_open_load,
  input  wire logic [1:0]  i_off_open_load,
  input  wire logic [1:0]  i_short_to_supply,
  input  wire logic [1:0]  i_pwm_off_clean,
  output logic [1:0]       o_channel_on,
  output logic [1:0]       o_oc_dur_reset,
  output logic             o_fail_safe,
  output logic             o_fault_flag_pin_n
);
  import switch_fault_pkg::*;
  logic        fail_safe_q;
  logic        supfail_en_q;
  logic        normal_mode_q;
  logic [1:0]  retry_en_bit_q;
  logic [1:0]  unlimited_q;
  logic [1:0]  period_q [2];
  word_t       channel_config_word_q [2];
  word_t       channel_fault_word_q [2];
  logic        por_flag_q;
  logic        awake_q;
  logic [1:0]  pwr_por_q;
  logic        wake;
  logic        por_event;
  logic        do_write;
  logic        do_read;
  logic        regs_clear;
  logic [1:0]  ch_sel;
  logic [1:0]  delatch;
  logic [1:0]  cnt_clear;
  logic [1:0]  retry_en;
  logic [1:0]  on_allow;
  logic [1:0]  latched;
  logic [1:0]  full;
  logic [1:0]  dur_rst;
  logic [3:0]  count [2];
  logic [1:0]  live_fault;

  // Single-cycle wait on every access keeps read data registered
  assign do_write = i_avm_write && o_avm_waitrequest == 1'b0;
  assign do_read  = i_avm_read && o_avm_waitrequest == 1'b0;
  always_ff @(posedge i_clk) begin
    if (i_rst)
      o_avm_waitrequest <= 1'b1;
    else if ((i_avm_read || i_avm_write) && o_avm_waitrequest)
      o_avm_waitrequest <= 1'b0;
    else
      o_avm_waitrequest <= 1'b1;
  end
  assign ch_sel = {i_avm_writedata[16], ~i_avm_writedata[16]};

  // Wake: either reset input or a direct input high
  assign wake = i_reset_wake_input_n | (|i_direct_in);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      awake_q   <= 1'b0;
      pwr_por_q <= 2'h3;
    end else begin
      awake_q   <= wake;
      pwr_por_q <= {i_power_supply_por, i_logic_supply_por};
    end
  end
  assign por_event = (pwr_por_q == 2'h3 && {i_power_supply_por, i_logic_supply_por} != 2'h3)
                   || (wake && !awake_q);

  // Fail-safe only with the enable set; otherwise serial control stays
  always_ff @(posedge i_clk) begin
    if (i_rst || por_event)
      fail_safe_q <= 1'b0;
    else if (!i_logic_supply_ok && supfail_en_q)
      fail_safe_q <= 1'b1;
    else if (i_logic_supply_ok)
      fail_safe_q <= 1'b0;
  end
  assign regs_clear = i_rst || por_event || (!i_logic_supply_ok && supfail_en_q);
  always_ff @(posedge i_clk) o_fail_safe <= !i_rst && fail_safe_q;

  // Register writes are not gated by power undervoltage
  always_ff @(posedge i_clk) begin
    if (regs_clear) begin
      supfail_en_q  <= 1'b0;
      normal_mode_q <= 1'b0;
    end else if (do_write && i_avm_address == `ADDR_CTRL) begin
      supfail_en_q  <= i_avm_writedata[`CTRL_SUPFAIL_EN];
      normal_mode_q <= i_avm_writedata[`CTRL_NORMAL_MODE];
    end
  end
  assign delatch = (do_write && i_avm_address == `ADDR_CTRL)
                 ? i_avm_writedata[`CTRL_DELATCH1:`CTRL_DELATCH0] : 2'h0;

  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      logic wr_retry;
      logic new_en;
      logic new_unl;
      logic unl_now;
      assign wr_retry = do_write && i_avm_address == `ADDR_RETRY && ch_sel[c];
      assign new_en   = i_avm_writedata[`RETRY_EN_BIT];
      assign new_unl  = i_avm_writedata[`RETRY_UNLIM_BIT];
      // New unlimited setting seen in the write cycle so a latched channel can restart
      assign unl_now  = unlimited_q[c] | (wr_retry && new_unl);
      always_ff @(posedge i_clk) begin
        if (regs_clear) begin
          retry_en_bit_q[c] <= 1'b0;
          unlimited_q[c]    <= 1'b0;
          period_q[c]       <= 2'h0;
        end else if (wr_retry) begin
          retry_en_bit_q[c] <= new_en;
          unlimited_q[c]    <= new_unl;
          period_q[c]       <= i_avm_writedata[`RETRY_PER_HI:`RETRY_PER_LO];
        end
      end
      always_ff @(posedge i_clk) begin
        if (regs_clear)
          channel_config_word_q[c] <= 16'h0000;
        else if (do_write && i_avm_address == `ADDR_CONFIG && ch_sel[c])
          channel_config_word_q[c] <= i_avm_writedata[15:0];
      end
      assign retry_en[c] = (retry_en_bit_q[c] == i_load_type_select[c]);
      assign cnt_clear[c] = regs_clear || (wake && !awake_q)
                          || (wr_retry && new_unl && !unlimited_q[c])
                          || (wr_retry && retry_en[c]
                              && new_en != i_load_type_select[c]);
      // Passive fault bits and bit 0 for overcurrent, short or overtemperature: set wins over the read clear
      always_ff @(posedge i_clk) begin
        if (regs_clear) begin
          channel_fault_word_q[c] <= 16'h0000;
        end else begin
          if (do_read && i_avm_address == `ADDR_FAULT)
            channel_fault_word_q[c] <= 16'h0000;
          if (i_on_open_load[c] && !channel_config_word_q[c][`CFG_ON_OL_DIS])
            channel_fault_word_q[c][`CFG_ON_OL_DIS] <= 1'b1;
          if (i_off_open_load[c] && !channel_config_word_q[c][`CFG_OFF_OL_DIS])
            channel_fault_word_q[c][`CFG_OFF_OL_DIS] <= 1'b1;
          if (i_short_to_supply[c] && !channel_config_word_q[c][`CFG_OS_DIS])
            channel_fault_word_q[c][`CFG_OS_DIS] <= 1'b1;
          if (i_overcurrent_fault[c] | i_severe_short_fault[c] | i_overtemperature_fault[c])
            channel_fault_word_q[c][0] <= 1'b1;
        end
      end
      assign live_fault[c] = (i_on_open_load[c] && !channel_config_word_q[c][`CFG_ON_OL_DIS])
                           || (i_off_open_load[c] && !channel_config_word_q[c][`CFG_OFF_OL_DIS])
                           || (i_short_to_supply[c] && !channel_config_word_q[c][`CFG_OS_DIS]);
      retry_channel u_retry (
        .i_clk                   (i_clk),
        .i_rst                   (i_rst),
        .i_cnt_clear             (cnt_clear[c]),
        .i_retry_en              (retry_en[c]),
        .i_unlimited             (unl_now),
        .i_period_sel            (period_q[c]),
        .i_fault_control_signal  (i_fault_control_signal[c]),
        .i_overcurrent_fault     (i_overcurrent_fault[c]),
        .i_severe_short_fault    (i_severe_short_fault[c]),
        .i_overtemperature_fault (i_overtemperature_fault[c]),
        .i_undervoltage_fault    (i_undervoltage_fault),
        .i_delatch               (delatch[c]),
        .i_motor                 (i_load_type_select[c]),
        .i_pwm_off_clean         (i_pwm_off_clean[c]),
        .o_on_allow              (on_allow[c]),
        .o_latched               (latched[c]),
        .o_full                  (full[c]),
        .o_oc_dur_reset          (dur_rst[c]),
        .o_count                 (count[c])
      );
      // Fail-safe hands the channel to its direct input
      always_ff @(posedge i_clk) begin
        if (i_rst)
          o_channel_on[c] <= 1'b0;
        else if (fail_safe_q)
          o_channel_on[c] <= i_direct_in[c];
        else
          o_channel_on[c] <= on_allow[c];
      end
    end
  endgenerate
  always_ff @(posedge i_clk) o_oc_dur_reset <= i_rst ? 2'h0 : dur_rst;

  // Power-on-reset flag; set wins over the read clear
  always_ff @(posedge i_clk) begin
    if (i_rst)
      por_flag_q <= 1'b1;
    else if (por_event)
      por_flag_q <= 1'b1;
    else if (do_read && i_avm_address == `ADDR_STATUS)
      por_flag_q <= 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst)
      o_fault_flag_pin_n <= 1'b1;
    else
      o_fault_flag_pin_n <= !(|latched) && !(|live_fault);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avm_readdata <= 32'h00000000;
    end else if (i_avm_read && o_avm_waitrequest) begin
      // Taken on the wait cycle so data stands at the accepting edge
      case (i_avm_address)
        `ADDR_CTRL:     o_avm_readdata <= {30'h0, normal_mode_q, supfail_en_q};
        `ADDR_RETRY:    o_avm_readdata <= {24'h0, period_q[1], unlimited_q[1], retry_en_bit_q[1],
                                            period_q[0], unlimited_q[0], retry_en_bit_q[0]};
        `ADDR_CONFIG:   o_avm_readdata <= {channel_config_word_q[1], channel_config_word_q[0]};
        `ADDR_STATUS:   o_avm_readdata <= {25'h0, por_flag_q, full, 1'b0, fail_safe_q, latched};
        `ADDR_FAULT:    o_avm_readdata <= {channel_fault_word_q[1], channel_fault_word_q[0]};
        `ADDR_RETRYCNT: o_avm_readdata <= normal_mode_q ? {16'h0, count[1], 4'h0, count[0], 4'h0}
                                                        : 32'h00000000;
        default:        o_avm_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

/* switch_fault_autoretry_asserts.sv */
// Port-level assertions for the fault recovery block
`timescale 1ns/100ps
`default_nettype none
module switch_fault_autoretry_asserts (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_avm_read,
  input wire logic       i_avm_write,
  input wire logic       o_avm_waitrequest,
  input wire logic       i_logic_supply_ok,
  input wire logic [1:0] i_direct_in,
  input wire logic       i_undervoltage_fault,
  input wire logic [1:0] i_load_type_select,
  input wire logic [1:0] i_pwm_off_clean,
  input wire logic [1:0] o_channel_on,
  input wire logic [1:0] o_oc_dur_reset,
  input wire logic       o_fail_safe,
  input wire logic       o_fault_flag_pin_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // First cycle of a request, before any answer
  sequence new_req;
    (i_avm_read || i_avm_write) && o_avm_waitrequest && !$past(i_avm_read || i_avm_write);
  endsequence
  sequence uv_with_logic;
    i_undervoltage_fault && i_logic_supply_ok;
  endsequence
  chk_reset_state: assert property (disable iff (1'b0) i_rst |=> o_avm_waitrequest && o_channel_on == 2'b00
    && o_fault_flag_pin_n && !o_fail_safe) else $error("outputs not at reset values");
  chk_wait_answer: assert property (new_req |=> !o_avm_waitrequest) else $error("no answer after one wait");
  chk_wait_single: assert property (!o_avm_waitrequest |=> o_avm_waitrequest) else $error("answer held too long");
  chk_uv_access: assert property (new_req ##0 uv_with_logic |=> !o_avm_waitrequest)
    else $error("bus blocked in undervoltage");
  chk_failsafe_cause: assert property ($rose(o_fail_safe) |-> !$past(i_logic_supply_ok, 2))
    else $error("fail-safe without supply loss");
  chk_failsafe_drive: assert property (o_fail_safe && $past(o_fail_safe) && $stable(i_direct_in)
    && !i_undervoltage_fault |-> o_channel_on == i_direct_in)
    else $error("fail-safe channels not following direct inputs");
  chk_uv_off: assert property (i_undervoltage_fault[*4] |-> o_channel_on == 2'b00)
    else $error("channel on during undervoltage");
  chk_dur_pulse: assert property (o_oc_dur_reset[0] |=> !o_oc_dur_reset[0])
    else $error("duration reset not a pulse");
  chk_motor_clean: assert property ($past(i_load_type_select[1], 2) && o_oc_dur_reset[1]
    |-> $past(i_pwm_off_clean[1], 2))
    else $error("motor duration reset without clean period");
endmodule
bind switch_fault_autoretry switch_fault_autoretry_asserts u_chk (.i_clk, .i_rst, .i_avm_read, .i_avm_write,
  .o_avm_waitrequest, .i_logic_supply_ok, .i_direct_in, .i_undervoltage_fault, .i_load_type_select,
  .i_pwm_off_clean, .o_channel_on, .o_oc_dur_reset, .o_fail_safe, .o_fault_flag_pin_n);
`default_nettype wire

/* host_model.sv */
// Host controller model: register bus master and reset-wake pin
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic        i_clk,
  input  wire logic        i_avm_waitrequest,
  input  wire logic [31:0] i_avm_readdata,
  output logic [3:0]       o_avm_address,
  output logic             o_avm_read,
  output logic             o_avm_write,
  output logic [31:0]      o_avm_writedata,
  output logic             o_reset_wake_input_n
);
  bit timed_out = 1'b0;
  initial begin
    o_avm_address = 4'h0;
    o_avm_read = 1'b0;
    o_avm_write = 1'b0;
    o_avm_writedata = 32'h0;
    o_reset_wake_input_n = 1'b1;
  end
  // Read data stands at the accepting edge and is taken there
  task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge i_clk);
    o_avm_address <= a;
    o_avm_writedata <= wd;
    o_avm_read <= !wr;
    o_avm_write <= wr;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_avm_waitrequest && n < 50);
    if (i_avm_waitrequest) timed_out = 1'b1;
    rd = i_avm_readdata;
    o_avm_read <= 1'b0;
    o_avm_write <= 1'b0;
  endtask
  task automatic wake();
    @(posedge i_clk);
    o_reset_wake_input_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_reset_wake_input_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* switch_fault_autoretry_tb_top.sv */
// Self-checking testbench for the fault recovery block
`timescale 1ns/100ps
`default_nettype none
`include "switch_fault_defs.svh"
module switch_fault_autoretry_tb_top;
  import switch_fault_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        supply_ok = 1'b1;
  logic        uv = 1'b0;
  logic [1:0]  direct_in = 2'b00;
  logic [1:0]  load_type = 2'b00;
  logic [1:0]  oc = 2'b00;
  logic [1:0]  fc = 2'b11;
  logic [1:0]  pwm_clean = 2'b00;
  logic [1:0]  pas [3];
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        wake_n;
  logic [1:0]  channel_on;
  logic        fail_safe;
  logic        pin_n;
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #50 i_clk = ~i_clk;
  initial begin
    pas[0] = 2'b00;
    pas[1] = 2'b00;
    pas[2] = 2'b00;
  end
  host_model u_host (.i_clk(i_clk), .i_avm_waitrequest(waitrequest), .i_avm_readdata(readdata),
    .o_avm_address(address), .o_avm_read(read), .o_avm_write(write), .o_avm_writedata(writedata),
    .o_reset_wake_input_n(wake_n));
  // Power-on-reset, short and overtemperature inputs are tied off to keep the run short
  switch_fault_autoretry u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_avm_address(address), .i_avm_read(read),
    .i_avm_write(write), .i_avm_writedata(writedata), .o_avm_readdata(readdata), .o_avm_waitrequest(waitrequest),
    .i_logic_supply_ok(supply_ok), .i_power_supply_por(1'b0), .i_logic_supply_por(1'b0),
    .i_reset_wake_input_n(wake_n), .i_direct_in(direct_in), .i_load_type_select(load_type),
    .i_fault_control_signal(fc), .i_overcurrent_fault(oc), .i_severe_short_fault(2'b00),
    .i_overtemperature_fault(2'b00), .i_undervoltage_fault(uv), .i_on_open_load(pas[2]),
    .i_off_open_load(pas[1]), .i_short_to_supply(pas[0]), .i_pwm_off_clean(pwm_clean),
    .o_channel_on(channel_on), .o_oc_dur_reset(), .o_fail_safe(fail_safe), .o_fault_flag_pin_n(pin_n));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    u_host.access(1'b0, a, 32'h0, d);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] t;
    u_host.access(1'b1, a, d, t);
  endtask
  task automatic do_reset();
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask
  task automatic t_por();
    logic [31:0] d;
    do_reset();
    rd(`ADDR_STATUS, d);
    check(d & 32'h40, 32'h40);
    rd(`ADDR_STATUS, d);
    check(d & 32'h40, 32'h0);
    u_host.wake();
    rd(`ADDR_STATUS, d);
    check(d & 32'h40, 32'h40);
    wr(4'hA, 32'hFFFF_FFFF);
    rd(4'hA, d);
    check(d, 32'h0);
  endtask
  task automatic t_supply();
    logic [31:0] d;
    int n;
    do_reset();
    supply_ok <= 1'b0;
    repeat (8) @(posedge i_clk);
    check(fail_safe, 1'b0);
    supply_ok <= 1'b1;
    wr(`ADDR_RETRY, 32'h0000_0004);
    wr(`ADDR_CTRL, 32'h1);
    direct_in <= 2'b01;
    supply_ok <= 1'b0;
    for (n = 0; n < 10 && fail_safe !== 1'b1; n++) @(posedge i_clk);
    check(fail_safe, 1'b1);
    repeat (3) @(posedge i_clk);
    check(channel_on, 2'b01);
    supply_ok <= 1'b1;
    direct_in <= 2'b00;
    for (n = 0; n < 10 && fail_safe !== 1'b0; n++) @(posedge i_clk);
    rd(`ADDR_RETRY, d);
    check(d, 32'h0);
    rd(`ADDR_CTRL, d);
    check(d[1:0], 2'b00);
  endtask
  task automatic t_uv();
    logic [31:0] d;
    do_reset();
    // Retry disabled on both channels: lamp wants 0, motor wants 1
    load_type <= 2'b10;
    wr(`ADDR_RETRY, 32'h0000_0001);
    uv <= 1'b1;
    wr(`ADDR_RETRY, 32'h0001_0008);
    rd(`ADDR_RETRY, d);
    check(d[7:0], 8'h81);
    check(pin_n, 1'b0);
    uv <= 1'b0;
    rd(`ADDR_STATUS, d);
    check(d[1:0], 2'b11);
    wr(`ADDR_RETRY, 32'h0000_0000);
    wr(`ADDR_RETRY, 32'h0000_0002);
    rd(`ADDR_STATUS, d);
    check(d[1:0], 2'b10);
  endtask
  task automatic t_retry();
    logic [31:0] d;
    int n;
    do_reset();
    load_type <= 2'b00;
    direct_in <= 2'b01;
    wr(`ADDR_RETRY, 32'h0);
    oc <= 2'b01;
    repeat (4) @(posedge i_clk);
    check(channel_on[0], 1'b0);
    oc <= 2'b00;
    // Period select 0 is the shortest retry time
    for (n = 0; n < 81000 && channel_on[0] !== 1'b1; n++) @(posedge i_clk);
    check(n >= 79900 && n <= 80010, 1'b1);
    check(pin_n, 1'b1);
    rd(`ADDR_RETRYCNT, d);
    check(d, 32'h0);
    wr(`ADDR_CTRL, 32'h2);
    rd(`ADDR_RETRYCNT, d);
    check(d[7:4], 4'h1);
    oc <= 2'b01;
    repeat (4) @(posedge i_clk);
    oc <= 2'b00;
    wr(`ADDR_CTRL, 32'h6);
    repeat (3) @(posedge i_clk);
    check(channel_on[0], 1'b1);
    rd(`ADDR_RETRYCNT, d);
    check(d[7:4], 4'h1);
    rd(`ADDR_FAULT, d);
    check(d[0], 1'b1);
    wr(`ADDR_RETRY, 32'h2);
    rd(`ADDR_RETRYCNT, d);
    check(d[7:4], 4'h0);
    fc <= 2'b00;
    oc <= 2'b01;
    repeat (4) @(posedge i_clk);
    check(channel_on[0], 1'b1);
    oc <= 2'b00;
    fc <= 2'b11;
    direct_in <= 2'b00;
  endtask
  task automatic t_passive();
    logic [31:0] d;
    do_reset();
    load_type <= 2'b10;
    pwm_clean <= 2'b10;
    @(posedge i_clk);
    pwm_clean <= 2'b00;
    for (int i = 0; i < 3; i++) begin
      pas[i] <= 2'b01;
      repeat (3) @(posedge i_clk);
      check(pin_n, 1'b0);
      pas[i] <= 2'b00;
      rd(`ADDR_FAULT, d);
      check(d[6+i], 1'b1);
      rd(`ADDR_STATUS, d);
      check(d[1:0], 2'b00);
      wr(`ADDR_CONFIG, 32'h1 << (6 + i));
      pas[i] <= 2'b01;
      repeat (3) @(posedge i_clk);
      check(pin_n, 1'b1);
      pas[i] <= 2'b00;
      rd(`ADDR_FAULT, d);
      check(d[6+i], 1'b0);
    end
  endtask
  task automatic final_report();
    if (u_host.timed_out) n_mismatch++;
    $display("Comparisons %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    t_por();
    t_supply();
    t_uv();
    t_passive();
    t_retry();
    final_report();
  end
endmodule
`default_nettype wire
